/* hdl/fsq_consts.vh */
// constants for the flash sequencer status, clear and stop slice
`ifndef FSQ_CONSTS_VH
`define FSQ_CONSTS_VH

// ************************************************************
// register offsets (byte addresses on the plain register port)
// ************************************************************
`define FSQ_AW              8
`define FSQ_A_ERR_STATUS    8'h00
`define FSQ_A_STATUS_HIGH   8'h01
`define FSQ_A_REG_INIT      8'h02
`define FSQ_A_AP_HIGH       8'h03
`define FSQ_A_AP_LOW        8'h04
`define FSQ_A_END_HIGH      8'h05
`define FSQ_A_END_LOW       8'h06
`define FSQ_A_WD_HIGH       8'h07
`define FSQ_A_WD_LOW        8'h08
`define FSQ_A_AREA_SEL      8'h09
`define FSQ_A_CFDF_CTRL     8'h0A
`define FSQ_A_EXTRA_CTRL    8'h0B
`define FSQ_A_MODE          8'h0C
`define FSQ_A_IRQ_STATUS    8'h0D
`define FSQ_A_IRQ_MASK      8'h0E

// ************************************************************
// field positions and values
// ************************************************************
`define FSQ_ERR_EXTRA       5
`define FSQ_ERR_CFDF        4
`define FSQ_ERR_BLANK       3
`define FSQ_ERR_VERIFY      2
`define FSQ_ERR_WRITE       1
`define FSQ_ERR_ERASE       0
`define FSQ_ERR_USED        6'h3F
`define FSQ_STH_CFDF_END    6
`define FSQ_STH_EXTRA_END   7
`define FSQ_CTRL_START      0
`define FSQ_CTRL_FSTOP      6
`define FSQ_INIT_ON         8'h01
`define FSQ_INIT_OFF        8'h00
`define FSQ_ZERO8           8'h00
`define FSQ_ZERO16          16'h0000
`define FSQ_ZERO6           6'h00
`define FSQ_ZERO4           4'h0
`define FSQ_MODE_NONE       2'h0
`define FSQ_IRQ_CFDF_DONE   0
`define FSQ_IRQ_EXTRA_DONE  1
`define FSQ_IRQ_ERR         2
`define FSQ_IRQ_STOPPED     3
// cycles a command keeps the sequencer busy in this model of the engine
`define FSQ_RUN_CYCLES      8'h10
`define FSQ_ONE8            8'h01

`endif

/* hdl/fsq_seq_engine.v */
// one sequencer engine: run, forced stop and end indication
`timescale 1ns/1ps
`default_nettype none
`include "fsq_consts.vh"

module fsq_seq_engine (
  input  wire       core_clk,   // system clock
  input  wire       rst,        // async reset, active high
  input  wire       start,      // control register start bit level
  input  wire       fstop,      // forced stop request level
  input  wire       fail,       // command error input from the array
  output reg        busy_r,     // command executing
  output reg        end_r,      // end indication, held until start clears
  output reg        done_r,     // one-cycle pulse at completion
  output reg        err_r,      // one-cycle pulse: completion with error
  output reg        stop_r      // one-cycle pulse: aborted by forced stop
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_RUN  = 3'b010;
  localparam [2:0] S_END  = 3'b100;

  reg [2:0] state_r;
  reg [7:0] cnt_r;

  // ************************************************************
  // sequence: idle -> run -> end, end held until start drops
  // ************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      cnt_r   <= `FSQ_ZERO8;
      busy_r  <= 1'b0;
      end_r   <= 1'b0;
      done_r  <= 1'b0;
      err_r   <= 1'b0;
      stop_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      err_r  <= 1'b0;
      stop_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start) begin
            state_r <= S_RUN;
            busy_r  <= 1'b1;
            cnt_r   <= `FSQ_RUN_CYCLES;
          end
        end
        S_RUN: begin
          // forced stop aborts at once, no completion check done
          if (fstop) begin
            state_r <= S_END;
            busy_r  <= 1'b0;
            end_r   <= 1'b1;
            stop_r  <= 1'b1;
          end else if (cnt_r == `FSQ_ONE8) begin
            state_r <= S_END;
            busy_r  <= 1'b0;
            end_r   <= 1'b1;
            done_r  <= 1'b1;
            err_r   <= fail;
          end else begin
            cnt_r <= cnt_r - `FSQ_ONE8;
          end
        end
        S_END: begin
          // end returns to zero only once software clears the control
          if (!start) begin
            state_r <= S_IDLE;
            end_r   <= 1'b0;
          end
        end
        default: begin
          state_r <= S_IDLE;
          busy_r  <= 1'b0;
          end_r   <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* hdl/fsq_irq.v */
// sticky event status with mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "fsq_consts.vh"

module fsq_irq (
  input  wire       core_clk,   // system clock
  input  wire       rst,        // async reset, active high
  input  wire [3:0] ev,         // event pulses
  input  wire       clr,        // read of status register: clear
  input  wire [3:0] mask,       // enable mask
  output reg  [3:0] status_r,   // sticky bits
  output reg        irq_r       // level interrupt
);

  // ************************************************************
  // sticky set wins over read clear so no event is lost
  // ************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_r <= `FSQ_ZERO4;
      irq_r    <= 1'b0;
    end else begin
      status_r <= (clr ? `FSQ_ZERO4 : status_r) | ev;
      irq_r    <= |(((clr ? `FSQ_ZERO4 : status_r) | ev) & mask);
    end
  end

endmodule
`default_nettype wire

/* hdl/fsq_top.v */
// flash sequencer pair: error status, register initialisation, forced stop
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "fsq_consts.vh"

// Behaviour
// - the error status register is 8 bits, flags in bits 5..0, bits 7..6 read zero.
// - bit 5 flags an extra area sequencer error and bit 4 a code/data sequencer error.
// - bits 3..0 flag blank check, internal verify, write and erase errors.
// - writing 0x01 then 0x00 to the init register clears the registers at 0x03..0x0B.
// - the init pulse leaves the error status untouched.
// - a forced stop aborts a running code/data sequencer command.
// - after control clear, end reads zero at bit 6 (code/data) and bit 7 (extra).
module fsq_top (
  input  wire       core_clk,    // system clock, 100 MHz
  input  wire       rst,         // async reset, active high
  input  wire [7:0] addr,        // register address
  input  wire [7:0] wdata,       // write data
  input  wire       wr,          // write strobe
  input  wire       rd,          // read strobe
  input  wire [1:0] cmd_kind_fail, // array fail result: [0] code/data, [1] extra
  output reg  [7:0] rdata_r,     // read data, valid cycle after rd
  output reg        cfdf_busy_r, // code/data sequencer executing
  output reg        extra_busy_r, // extra sequencer executing
  output reg        irq_r        // level interrupt
);

  // ************************************************************
  // software visible registers
  // ************************************************************
  reg  [7:0] init_r;
  reg  [7:0] ap_high_r;
  reg  [7:0] ap_low_r;
  reg  [7:0] end_high_r;
  reg  [7:0] end_low_r;
  reg  [7:0] wd_high_r;
  reg  [7:0] wd_low_r;
  reg  [7:0] area_sel_r;
  reg  [7:0] cfdf_ctrl_r;
  reg  [7:0] extra_ctrl_r;
  reg  [1:0] mode_r;
  reg  [5:0] err_r;
  reg  [3:0] irq_mask_r;
  wire       init_pulse;
  wire       c_busy;
  wire       c_end;
  wire       c_done;
  wire       c_err;
  wire       c_stop;
  wire       e_busy;
  wire       e_end;
  wire       e_done;
  wire       e_err;
  wire [7:0] mode_nxt;
  wire [7:0] irq_mask_nxt;
  wire [3:0] irq_status;
  wire       irq_w;
  wire       irq_clr;
  wire [5:0] err_set;

  // write helper shared by all plain registers
  function [7:0] wr_reg;
    input [7:0] cur;
    input [7:0] a;
    input [7:0] target;
    input       we;
    input [7:0] d;
    begin
      wr_reg = (we && (a == target)) ? d : cur;
    end
  endfunction

  // init fires on the falling 0x01 -> 0x00 write pair
  assign init_pulse = wr && (addr == `FSQ_A_REG_INIT) && (wdata == `FSQ_INIT_OFF)
                      && (init_r == `FSQ_INIT_ON);

  // narrow registers use the shared byte-wide helper, then keep only their own bits
  assign mode_nxt     = wr_reg({6'b0, mode_r}, addr, `FSQ_A_MODE, wr, wdata);
  assign irq_mask_nxt = wr_reg({4'b0, irq_mask_r}, addr, `FSQ_A_IRQ_MASK, wr, wdata);

  // ************************************************************
  // register writes and initialisation clear
  // ************************************************************
  // the clear ignores whether a sequencer runs; misuse is software's fault
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      init_r       <= `FSQ_ZERO8;
      ap_high_r    <= `FSQ_ZERO8;
      ap_low_r     <= `FSQ_ZERO8;
      end_high_r   <= `FSQ_ZERO8;
      end_low_r    <= `FSQ_ZERO8;
      wd_high_r    <= `FSQ_ZERO8;
      wd_low_r     <= `FSQ_ZERO8;
      area_sel_r   <= `FSQ_ZERO8;
      cfdf_ctrl_r  <= `FSQ_ZERO8;
      extra_ctrl_r <= `FSQ_ZERO8;
      mode_r       <= `FSQ_MODE_NONE;
      irq_mask_r   <= `FSQ_ZERO4;
    end else begin
      init_r     <= wr_reg(init_r, addr, `FSQ_A_REG_INIT, wr, wdata);
      mode_r     <= mode_nxt[1:0];
      irq_mask_r <= irq_mask_nxt[3:0];
      if (init_pulse) begin
        ap_high_r    <= `FSQ_ZERO8;
        ap_low_r     <= `FSQ_ZERO8;
        end_high_r   <= `FSQ_ZERO8;
        end_low_r    <= `FSQ_ZERO8;
        wd_high_r    <= `FSQ_ZERO8;
        wd_low_r     <= `FSQ_ZERO8;
        area_sel_r   <= `FSQ_ZERO8;
        cfdf_ctrl_r  <= `FSQ_ZERO8;
        extra_ctrl_r <= `FSQ_ZERO8;
      end else begin
        ap_high_r    <= wr_reg(ap_high_r, addr, `FSQ_A_AP_HIGH, wr, wdata);
        ap_low_r     <= wr_reg(ap_low_r, addr, `FSQ_A_AP_LOW, wr, wdata);
        end_high_r   <= wr_reg(end_high_r, addr, `FSQ_A_END_HIGH, wr, wdata);
        end_low_r    <= wr_reg(end_low_r, addr, `FSQ_A_END_LOW, wr, wdata);
        wd_high_r    <= wr_reg(wd_high_r, addr, `FSQ_A_WD_HIGH, wr, wdata);
        wd_low_r     <= wr_reg(wd_low_r, addr, `FSQ_A_WD_LOW, wr, wdata);
        area_sel_r   <= wr_reg(area_sel_r, addr, `FSQ_A_AREA_SEL, wr, wdata);
        cfdf_ctrl_r  <= wr_reg(cfdf_ctrl_r, addr, `FSQ_A_CFDF_CTRL, wr, wdata);
        extra_ctrl_r <= wr_reg(extra_ctrl_r, addr, `FSQ_A_EXTRA_CTRL, wr, wdata);
      end
    end
  end

  // ************************************************************
  // sequencer engines
  // ************************************************************
  fsq_seq_engine u_cfdf (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (cfdf_ctrl_r[`FSQ_CTRL_START]),
    .fstop    (cfdf_ctrl_r[`FSQ_CTRL_FSTOP]),
    .fail     (cmd_kind_fail[0]),
    .busy_r   (c_busy),
    .end_r    (c_end),
    .done_r   (c_done),
    .err_r    (c_err),
    .stop_r   (c_stop)
  );

  // the extra area sequencer has no forced stop
  fsq_seq_engine u_extra (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (extra_ctrl_r[`FSQ_CTRL_START]),
    .fstop    (1'b0),
    .fail     (cmd_kind_fail[1]),
    .busy_r   (e_busy),
    .end_r    (e_end),
    .done_r   (e_done),
    .err_r    (e_err),
    .stop_r   ()
  );

  // ************************************************************
  // error status: set by completions, a new code/data start clears old flags
  // ************************************************************
  // the failing command kind is taken from area select bits 3..0
  assign err_set = {e_err, c_err, (c_err | e_err) ? area_sel_r[3:0] : `FSQ_ZERO4};

  // a stopped command may leave flags; software must not trust them
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      err_r <= `FSQ_ZERO6;
    end else if (cfdf_ctrl_r[`FSQ_CTRL_START] && !c_busy && !c_end) begin
      err_r <= err_set; // new command starts with fresh flags
    end else begin
      err_r <= err_r | err_set; // init pulse has no effect here
    end
  end

  // ************************************************************
  // interrupt events
  // ************************************************************
  assign irq_clr = rd && (addr == `FSQ_A_IRQ_STATUS);

  fsq_irq u_irq (
    .core_clk (core_clk),
    .rst      (rst),
    .ev       ({c_stop, c_err | e_err, e_done, c_done}),
    .clr      (irq_clr),
    .mask     (irq_mask_r),
    .status_r (irq_status),
    .irq_r    (irq_w)
  );

  // ************************************************************
  // read port and registered outputs
  // ************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_r      <= `FSQ_ZERO8;
      cfdf_busy_r  <= 1'b0;
      extra_busy_r <= 1'b0;
      irq_r        <= 1'b0;
    end else begin
      cfdf_busy_r  <= c_busy;
      extra_busy_r <= e_busy;
      irq_r        <= irq_w;
      rdata_r      <= `FSQ_ZERO8;
      if (rd) begin
        case (addr)
          `FSQ_A_ERR_STATUS:  rdata_r <= {2'b00, err_r & `FSQ_ERR_USED};
          `FSQ_A_STATUS_HIGH: rdata_r <= {e_end, c_end, 6'b0};
          `FSQ_A_REG_INIT:    rdata_r <= init_r;
          `FSQ_A_AP_HIGH:     rdata_r <= ap_high_r;
          `FSQ_A_AP_LOW:      rdata_r <= ap_low_r;
          `FSQ_A_END_HIGH:    rdata_r <= end_high_r;
          `FSQ_A_END_LOW:     rdata_r <= end_low_r;
          `FSQ_A_WD_HIGH:     rdata_r <= wd_high_r;
          `FSQ_A_WD_LOW:      rdata_r <= wd_low_r;
          `FSQ_A_AREA_SEL:    rdata_r <= area_sel_r;
          `FSQ_A_CFDF_CTRL:   rdata_r <= cfdf_ctrl_r;
          `FSQ_A_EXTRA_CTRL:  rdata_r <= extra_ctrl_r;
          `FSQ_A_MODE:        rdata_r <= {6'b0, mode_r};
          `FSQ_A_IRQ_STATUS:  rdata_r <= {4'b0, irq_status};
          `FSQ_A_IRQ_MASK:    rdata_r <= {4'b0, irq_mask_r};
          default:            rdata_r <= `FSQ_ZERO8;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* sim/fsq_properties.sv */
// checker for the flash sequencer status, clear and stop slice
`timescale 1ns/1ps
`default_nettype none
module fsq_properties (
  input wire logic       core_clk,      // system clock
  input wire logic       rst,           // async reset
  input wire logic [7:0] addr,          // register address
  input wire logic [7:0] wdata,         // write data
  input wire logic       wr,            // write strobe
  input wire logic       rd,            // read strobe
  input wire logic [1:0] cmd_kind_fail, // array fail inputs
  input wire logic [7:0] rdata_r,       // read data
  input wire logic       cfdf_busy_r,   // code/data busy
  input wire logic       extra_busy_r,  // extra busy
  input wire logic       irq_r          // interrupt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ********
  // error status, init pulse, stop and end flags
  // ********
  a_err_top_zero: assert property (
    rd && addr == 8'h00 |=> rdata_r[7:6] == 2'b00) else $error("error status top bits set");
  a_init_keeps_err: assert property (
    (rd && addr == 8'h00 && !cfdf_busy_r && !extra_busy_r) ##1 (wr && addr == 8'h02 &&
    wdata == 8'h01) ##1 (wr && addr == 8'h02 && wdata == 8'h00) ##1 (rd && addr == 8'h00)
    |=> rdata_r == $past(rdata_r, 3)) else $error("init pulse changed error status");
  a_init_zeroes: assert property (
    (wr && addr == 8'h02 && wdata == 8'h01) ##1 (wr && addr == 8'h02 && wdata == 8'h00)
    ##1 (rd && addr >= 8'h03 && addr <= 8'h0b) |=> rdata_r == 8'h00)
    else $error("register not cleared by init pulse");
  // the stop takes the control register write, the engine a cycle, plus the busy output lag
  a_stop_aborts: assert property (
    wr && addr == 8'h0a && wdata[6] && cfdf_busy_r |-> ##[1:3] !cfdf_busy_r)
    else $error("forced stop did not end the run");
  a_cfdf_end_clr: assert property (
    (wr && addr == 8'h0a && wdata == 8'h00 && !cfdf_busy_r) ##2 (rd && addr == 8'h01)
    |=> !rdata_r[6]) else $error("code/data end flag stuck");
  a_extra_end_clr: assert property (
    (wr && addr == 8'h0b && wdata == 8'h00 && !extra_busy_r) ##2 (rd && addr == 8'h01)
    |=> !rdata_r[7]) else $error("extra end flag stuck");
  a_cfdf_err_flag: assert property (
    $fell(cfdf_busy_r) && cmd_kind_fail == 2'b01 ##[1:20] (rd && addr == 8'h00)
    |=> rdata_r[4]) else $error("code/data error not flagged");
  a_extra_err_flag: assert property (
    $fell(extra_busy_r) && cmd_kind_fail == 2'b10 ##[1:20] (rd && addr == 8'h00)
    |=> rdata_r[5]) else $error("extra error not flagged");
endmodule
bind fsq_top fsq_properties u_props (.core_clk(core_clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .cmd_kind_fail(cmd_kind_fail), .rdata_r(rdata_r),
  .cfdf_busy_r(cfdf_busy_r), .extra_busy_r(extra_busy_r), .irq_r(irq_r));
`default_nettype wire

/* sim/fsq_top_tb.sv */
// self-checking bench for the flash sequencer status, clear and stop slice
`timescale 1ns/1ps
`default_nettype none
`include "fsq_consts.vh"
module fsq_top_tb;
  logic       core_clk = 1'b0; // system clock
  logic       rst = 1'b1;      // reset
  logic [7:0] addr = 8'h00;    // register address
  logic [7:0] wdata = 8'h00;   // write data
  logic       wr = 1'b0;       // write strobe
  logic       rd = 1'b0;       // read strobe
  logic [1:0] fail = 2'b00;    // array fail inputs
  wire  [7:0] rdata_r;         // read data
  wire        cfdf_busy_r;     // code/data busy
  wire        extra_busy_r;    // extra busy
  wire        irq_r;           // interrupt
  int         n_errors = 0;    // mismatches
  int         checks_done = 0; // comparisons
  logic [7:0] v;               // last read value
  int         i;               // scenario loop index
  always #5 core_clk = ~core_clk;
  fsq_top uut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .cmd_kind_fail(fail), .rdata_r(rdata_r), .cfdf_busy_r(cfdf_busy_r),
    .extra_busy_r(extra_busy_r), .irq_r(irq_r));
  // ********
  // bus tasks
  // ********
  // strobes are held through one edge, so calls chain with no gap
  task bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
  endtask
  task idle;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  // data stand only in the cycle after the strobe: take them at the next edge,
  // before that edge's updates land, so every drive stays on a rising edge
  task rreg(input logic [7:0] a);
    bus(1'b0, 1'b1, a, 8'h00);
    rd <= 1'b0;
    @(posedge core_clk);
    v = rdata_r;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    rreg(a);
    chk(v, exp);
  endtask
  // bounded wait for both sequencers to fall idle
  task wait_idle;
    int j;
    for (j = 0; j < 40 && (cfdf_busy_r !== 1'b0 || extra_busy_r !== 1'b0); j++)
      @(posedge core_clk);
  endtask
  // ********
  // scenarios
  // ********
  task t_reset;
    for (i = 0; i < 16; i++) rchk(8'(i), 8'h00);
    rchk(8'h20, 8'h00);
    $display("reset values done");
  endtask
  task t_regs;
    wreg(`FSQ_A_MODE, 8'h01);
    for (i = 3; i < 10; i++) wreg(8'(i), 8'(i) ^ 8'ha5);
    wreg(`FSQ_A_ERR_STATUS, 8'hff);
    for (i = 3; i < 10; i++) rchk(8'(i), 8'(i) ^ 8'ha5);
    rchk(`FSQ_A_ERR_STATUS, 8'h00);
    $display("register access done");
  endtask
  // each command kind in turn; a new start reloads the flags
  task t_cfdf;
    for (i = 0; i < 4; i++) begin
      fail <= 2'b01;
      wreg(`FSQ_A_AREA_SEL, 8'h01 << i);
      wreg(`FSQ_A_CFDF_CTRL, 8'h01);
      repeat (3) idle;
      wait_idle;
      rchk(`FSQ_A_STATUS_HIGH, 8'h40);
      wreg(`FSQ_A_CFDF_CTRL, 8'h00);
      idle;
      rchk(`FSQ_A_STATUS_HIGH, 8'h00);
      rchk(`FSQ_A_ERR_STATUS, 8'h10 | (8'h01 << i));
    end
    $display("code/data errors done");
  endtask
  task t_extra;
    fail <= 2'b10;
    wreg(`FSQ_A_EXTRA_CTRL, 8'h01);
    repeat (3) idle;
    chk(extra_busy_r, 8'h01);
    wait_idle;
    rchk(`FSQ_A_STATUS_HIGH, 8'h80);
    wreg(`FSQ_A_EXTRA_CTRL, 8'h00);
    idle;
    rchk(`FSQ_A_STATUS_HIGH, 8'h00);
    rchk(`FSQ_A_ERR_STATUS, 8'h38);
    $display("extra error done");
  endtask
  task t_init;
    // read with the init pair right behind it; the read data stand at the first write's edge
    bus(1'b0, 1'b1, `FSQ_A_ERR_STATUS, 8'h00);
    wreg(`FSQ_A_REG_INIT, `FSQ_INIT_ON);
    chk(rdata_r, 8'h38);
    wreg(`FSQ_A_REG_INIT, `FSQ_INIT_OFF);
    rchk(`FSQ_A_ERR_STATUS, 8'h38);
    for (i = 3; i < 12; i++) wreg(8'(i), 8'h3c);
    for (i = 3; i < 12; i++) rchk(8'(i), 8'h3c);
    wreg(`FSQ_A_REG_INIT, `FSQ_INIT_ON);
    wreg(`FSQ_A_REG_INIT, `FSQ_INIT_OFF);
    for (i = 3; i < 12; i++) rchk(8'(i), 8'h00);
    $display("register init done");
  endtask
  // masked events first, then a stop that must raise only the stop event
  task t_stop;
    @(negedge core_clk);
    chk(irq_r, 8'h00);
    @(posedge core_clk);
    rchk(`FSQ_A_IRQ_STATUS, 8'h07);
    wreg(`FSQ_A_IRQ_MASK, 8'h08);
    fail <= 2'b00;
    wreg(`FSQ_A_CFDF_CTRL, 8'h01);
    repeat (4) idle;
    wreg(`FSQ_A_CFDF_CTRL, 8'h41);
    repeat (3) idle;
    @(negedge core_clk);
    chk(cfdf_busy_r, 8'h00);
    chk(irq_r, 8'h01);
    @(posedge core_clk);
    rchk(`FSQ_A_IRQ_STATUS, 8'h08);
    idle;
    @(negedge core_clk);
    chk(irq_r, 8'h00);
    @(posedge core_clk);
    wreg(`FSQ_A_CFDF_CTRL, 8'h00);
    idle;
    $display("forced stop done");
  endtask
  // ********
  // run control
  // ********
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_cfdf;
    t_extra;
    t_init;
    t_stop;
    close_out;
  end
  // the run needs well under a thousand cycles
  initial begin
    #50000;
    n_errors++;
    close_out;
  end
endmodule
`default_nettype wire
